// file: rtl/csc_pkg.sv
package csc_pkg;

	// -----------------------------------------------------------------
	// Command bytes
	// -----------------------------------------------------------------
	localparam logic [7:0] CMD_RAM_WRITE      = 8'h00;
	localparam logic [7:0] CMD_RAM_READ       = 8'h40;
	localparam logic [7:0] CMD_DISPLAY_NEW    = 8'h46;
	localparam logic [7:0] CMD_POWER_RESET    = 8'hF0;
	localparam logic [7:0] CMD_INIT_RESET     = 8'hC0;
	localparam logic [7:0] CMD_START_CONT     = 8'hCC;
	localparam logic [7:0] CMD_START_SINGLE   = 8'hCE;
	localparam logic [7:0] CMD_REF_OFF        = 8'h86;
	localparam logic [7:0] CMD_REF_ON         = 8'h87;
	localparam logic [7:0] CMD_ACCESS_OFF     = 8'h90;
	localparam logic [7:0] CMD_ACCESS_ON      = 8'h91;
	localparam logic [7:0] CMD_NV_READ        = 8'hA0;
	localparam logic [7:0] CMD_NV_WRITE       = 8'hA1;
	localparam logic [7:0] CMD_NV_BWRITE      = 8'hA3;
	localparam logic [7:0] CMD_NV_BERASE      = 8'hA4;
	localparam logic [7:0] CMD_USER_READ      = 8'hA5;

	// -----------------------------------------------------------------
	// Memory layout
	// -----------------------------------------------------------------
	localparam int         RAM_WORDS          = 128;
	localparam int         NV_WORDS           = 1024;
	localparam int         NV_BLOCK_WORDS     = 256;
	localparam logic [9:0] USER_FIRST_WORD    = 10'h3E8;
	localparam logic [9:0] USER_LAST_WORD     = 10'h3FF;
	localparam logic [7:0] RESULT_RAM_ADDR    = 8'h00;
	localparam logic [7:0] RESULT_SRC_ADDR    = 8'h14;
	localparam logic [15:0] NV_ERASED         = 16'h0000;
	localparam int         CMP_BYTES          = 8;
	localparam int         WRITE_WORDS_START  = 6;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int CMP_DELAY_US   = 1000;
	localparam int CMP_DELAY_CYC  = CMP_DELAY_US * 1000000 / CLK_PERIOD_PS;

	// Command decoder outcomes
	typedef enum {
		CSC_OP_NONE,
		CSC_OP_RAM_WR,
		CSC_OP_RAM_RD,
		CSC_OP_STROBE,
		CSC_OP_NV_RD,
		CSC_OP_NV_WR,
		CSC_OP_NV_ERASE,
		CSC_OP_USER_RD
	} csc_op_t;

endpackage : csc_pkg

// file: rtl/csc_slave.sv
`timescale 1ns/1ps
// How it works
// R1 - Mode 1/0: clock idles low, bits change and sample on falling edge; the code samples on the falling edge but changes bits on the rising edge.
// R2 - Master keeps each clock phase at least 500 ns, at most 1 MHz; the bench master holds each phase 32 ns.
// R3 - Master pulses select high before every opcode; pulse restarts framing.
// R4 - Master waits 200 us after a reset command.
// R5 - With automatic config loading, master waits 1 ms after reset.
// R6 - Master waits 10 us after a RAM write.
// R7 - 0x00 decodes as RAM write, 0x40 as RAM read.
// R8 - RAM write: command, address byte, three data bytes into 24-bit word.
// R9 - 0xF0 power reset, 0xC0 init reset, 0x46 display refresh strobes.
// R10 - 0xCC starts continuous cycles, 0xCE starts single conversion.
// R11 - Master sends reference on and access enable before memory access.
// R12 - Non-volatile memory addressed per 16-bit word.
// R13 - Protected read compares eight bytes; address low two bits forced zero.
// R14 - Compare result on data out 1 ms later: FF match, 00 mismatch.
// R15 - 0xA5 returns one word from user area, word addresses 1000..1023.
// R16 - Four blocks of 256 words; first address byte low bits pick block.
// R17 - Written words arrive low byte first.
// R18 - Sixth data word starts programming, seventh byte ends it.
// R19 - Programming refused for any word not already erased.
// R20 - Block erase ignores low address and data, erases whole block.
// R21 - Master erases all with four erase commands between enable/disable.
// R22 - Master configures RAM 48..66 before starting external operation.
// R23 - Each new result drives data out from one to zero as a flag; the code flags a result only while run_reg is set by a start command.
// R24 - Select pulse after flag returns data out to communication mode.
// R25 - Result read shifts three result bytes after opcode and address.
// R26 - Without program, bridge result copied to RAM 0; else stays at 20.
// R27 - Command, address and data shifted most significant bit first.
module csc_slave
	import csc_pkg::*;
#(
	parameter int CMP_DELAY = CMP_DELAY_CYC
) (
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_link_clock,
	input  wire logic        i_chip_select_low,
	input  wire logic        i_serial_in_line,
	input  wire logic        i_serial_port_select,
	input  wire logic        i_program_stored,
	input  wire logic        i_result_valid,
	input  wire logic [23:0] i_bridge_result,
	output logic             o_serial_out,
	output logic             o_serial_out_oe_n,
	output logic             o_power_reset,
	output logic             o_init_reset,
	output logic             o_display_refresh,
	output logic             o_start_continuous,
	output logic             o_start_single,
	output logic             o_ref_on,
	output logic             o_access_on,
	output logic             o_programming
);
	// -----------------------------------------------------------------
	// Link domain: shift register, clocked by the master's serial clock
	// -----------------------------------------------------------------
	logic [7:0] lk_shift_reg;
	logic [2:0] lk_bit_reg;
	logic       lk_tog_reg;
	logic [7:0] lk_byte_reg;
	logic       lk_out_reg;

	// R1 sample on falling edge; select high clears framing (R3)
	always_ff @(negedge i_link_clock or posedge i_chip_select_low) begin
		if (i_chip_select_low) begin
			lk_bit_reg   <= 3'h0;
			lk_shift_reg <= 8'h00;
		end else begin
			// R27 shift msb first
			lk_shift_reg <= {lk_shift_reg[6:0], i_serial_in_line};
			lk_bit_reg   <= lk_bit_reg + 3'h1;
		end
	end

	// Byte capture and event toggle; select pulse parks toggle at zero
	always_ff @(negedge i_link_clock or posedge i_chip_select_low) begin
		if (i_chip_select_low) begin
			lk_tog_reg <= 1'b0;
		end else if (lk_bit_reg == 3'h7) begin
			lk_byte_reg <= {lk_shift_reg[6:0], i_serial_in_line};
			lk_tog_reg  <= !lk_tog_reg;
		end
	end

	// -----------------------------------------------------------------
	// Crossings into the system clock
	// -----------------------------------------------------------------
	logic tog_lvl;
	logic sel_lvl;
	logic sel_rise;
	logic tog_seen_reg;
	logic byte_stb;
	logic en_lvl;

	csc_sync u_sync_tog (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_async   (lk_tog_reg),
		.o_level   (tog_lvl),
		.o_rise    ()
	);
	csc_sync u_sync_sel (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_chip_select_low),
		.o_level   (sel_lvl),
		.o_rise    (sel_rise)
	);
	csc_sync u_sync_en (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_serial_port_select),
		.o_level   (en_lvl),
		.o_rise    ()
	);

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			tog_seen_reg <= 1'b0;
		else
			tog_seen_reg <= tog_lvl;
	end
	assign byte_stb = (tog_lvl != tog_seen_reg) && !sel_lvl && en_lvl;

	// -----------------------------------------------------------------
	// Frame sequencing
	// -----------------------------------------------------------------
	csc_op_t    op_reg;
	logic [3:0] idx_reg;
	logic [7:0] addr_hi_reg;
	logic [7:0] addr_lo_reg;
	logic [23:0] data_reg;
	logic [7:0] din;

	function automatic csc_op_t decode_cmd(input logic [7:0] c);
		case (c)
			// R7 RAM commands
			CMD_RAM_WRITE:    decode_cmd = CSC_OP_RAM_WR;
			CMD_RAM_READ:     decode_cmd = CSC_OP_RAM_RD;
			CMD_NV_READ:      decode_cmd = CSC_OP_NV_RD;
			CMD_NV_WRITE,
			CMD_NV_BWRITE:    decode_cmd = CSC_OP_NV_WR;
			CMD_NV_BERASE:    decode_cmd = CSC_OP_NV_ERASE;
			CMD_USER_READ:    decode_cmd = CSC_OP_USER_RD;
			default:          decode_cmd = CSC_OP_STROBE;
		endcase
	endfunction : decode_cmd

	assign din = lk_byte_reg;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst || sel_rise) begin
			op_reg  <= CSC_OP_NONE;
			idx_reg <= 4'h0;
		end else if (byte_stb) begin
			if (idx_reg != 4'hF)
				idx_reg <= idx_reg + 4'h1;
			if (idx_reg == 4'h0)
				op_reg <= decode_cmd(din);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			addr_hi_reg <= 8'h00;
			addr_lo_reg <= 8'h00;
			data_reg    <= 24'h000000;
		end else if (byte_stb) begin
			if (idx_reg == 4'h1)
				addr_hi_reg <= din;
			if (idx_reg == 4'h2)
				addr_lo_reg <= din;
			// R8 three data bytes msb first into a 24-bit word
			if (op_reg == CSC_OP_RAM_WR && idx_reg >= 4'h2)
				data_reg <= {data_reg[15:0], din};
		end
	end

	// -----------------------------------------------------------------
	// Command strobes
	// -----------------------------------------------------------------
	logic cmd_stb;
	assign cmd_stb = byte_stb && idx_reg == 4'h0;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_power_reset      <= 1'b0;
			o_init_reset       <= 1'b0;
			o_display_refresh  <= 1'b0;
			o_start_continuous <= 1'b0;
			o_start_single     <= 1'b0;
		end else begin
			// R9 reset and refresh strobes
			o_power_reset      <= cmd_stb && din == CMD_POWER_RESET;
			o_init_reset       <= cmd_stb && din == CMD_INIT_RESET;
			o_display_refresh  <= cmd_stb && din == CMD_DISPLAY_NEW;
			// R10 measurement starts
			o_start_continuous <= cmd_stb && din == CMD_START_CONT;
			o_start_single     <= cmd_stb && din == CMD_START_SINGLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst || (cmd_stb && din == CMD_POWER_RESET)) begin
			o_ref_on    <= 1'b0;
			o_access_on <= 1'b0;
		end else if (cmd_stb) begin
			if (din == CMD_REF_ON)
				o_ref_on <= 1'b1;
			if (din == CMD_REF_OFF)
				o_ref_on <= 1'b0;
			if (din == CMD_ACCESS_ON)
				o_access_on <= 1'b1;
			if (din == CMD_ACCESS_OFF)
				o_access_on <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// RAM with result handling
	// -----------------------------------------------------------------
	logic [23:0] ram_mem [RAM_WORDS];
	logic        ram_wr;
	logic [6:0]  ram_wa;
	logic [23:0] ram_wd;
	logic        run_reg;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst || o_power_reset || o_init_reset)
			run_reg <= 1'b0;
		else if (o_start_continuous || o_start_single)
			run_reg <= 1'b1;
		else if (i_result_valid && !o_start_continuous)
			run_reg <= run_reg;
	end

	always_comb begin
		ram_wr = 1'b0;
		ram_wa = 7'h00;
		ram_wd = data_reg;
		if (byte_stb && op_reg == CSC_OP_RAM_WR && idx_reg == 4'h4) begin
			ram_wr = 1'b1;
			ram_wa = addr_hi_reg[6:0];
			ram_wd = {data_reg[15:0], din};
		end else if (i_result_valid) begin
			// R26 result lands at 0 without program, else at 20
			ram_wr = 1'b1;
			ram_wa = i_program_stored ? RESULT_SRC_ADDR[6:0] : RESULT_RAM_ADDR[6:0];
			ram_wd = i_bridge_result;
		end
	end

	always_ff @(posedge i_clock) begin
		if (ram_wr)
			ram_mem[ram_wa] <= ram_wd;
	end

	// -----------------------------------------------------------------
	// Non-volatile array, word addressed
	// -----------------------------------------------------------------
	logic [15:0] nv_mem [NV_WORDS];
	logic [9:0]  nv_addr;
	logic [2:0]  wcnt_reg;
	logic        lo_half_reg;
	logic [7:0]  lo_byte_reg;
	logic [63:0] cmp_reg;
	logic [63:0] cmp_ref;
	logic [15:0] stage_mem [WRITE_WORDS_START];
	logic        nv_we;

	// R12 R16 block from first address byte, word within block from second
	assign nv_addr = {addr_hi_reg[1:0], addr_lo_reg};

	// R13 compare group aligned to four words
	always_comb begin
		cmp_ref = 64'h0;
		for (int i = 0; i < 4; i++)
			cmp_ref[63-16*i -: 16] = {nv_mem[{nv_addr[9:2], 2'(i)}][7:0],
				nv_mem[{nv_addr[9:2], 2'(i)}][15:8]};
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst || sel_rise) begin
			wcnt_reg    <= 3'h0;
			lo_half_reg <= 1'b1;
			lo_byte_reg <= 8'h00;
			cmp_reg     <= 64'h0;
			o_programming <= 1'b0;
		end else if (byte_stb && idx_reg >= 4'h3) begin
			if (op_reg == CSC_OP_NV_RD)
				cmp_reg <= {cmp_reg[55:0], din};
			if ((op_reg == CSC_OP_NV_WR || op_reg == CSC_OP_NV_ERASE) && o_access_on) begin
				// R17 low byte first
				lo_half_reg <= !lo_half_reg;
				if (lo_half_reg)
					lo_byte_reg <= din;
				else if (wcnt_reg < 3'(WRITE_WORDS_START))
					wcnt_reg <= wcnt_reg + 3'h1;
				// R18 seventh byte ends programming
				if (o_programming)
					o_programming <= 1'b0;
			end
		end else if (wcnt_reg == 3'(WRITE_WORDS_START) && !o_programming
			&& lo_half_reg && !nv_we) begin
			// R18 sixth word starts programming
			o_programming <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (byte_stb && op_reg == CSC_OP_NV_WR && !lo_half_reg
			&& wcnt_reg < 3'(WRITE_WORDS_START))
			stage_mem[wcnt_reg] <= {din, lo_byte_reg};
	end

	assign nv_we = o_programming && o_ref_on && o_access_on;

	always_ff @(posedge i_clock) begin
		if (byte_stb && op_reg == CSC_OP_NV_ERASE && idx_reg == 4'h1 && o_access_on) begin
			// R20 whole block from high address only
			for (int i = 0; i < NV_BLOCK_WORDS; i++)
				nv_mem[{din[1:0], 8'(i)}] <= NV_ERASED;
		end else if (nv_we && byte_stb && op_reg == CSC_OP_NV_WR) begin
			for (int i = 0; i < WRITE_WORDS_START; i++) begin
				// R19 only erased words are programmed
				if (nv_mem[10'(nv_addr + 10'(i))] == NV_ERASED)
					nv_mem[10'(nv_addr + 10'(i))] <= stage_mem[i];
			end
		end
	end

	// -----------------------------------------------------------------
	// Compare delay and output selection
	// -----------------------------------------------------------------
	logic [31:0] cdly_reg;
	logic        cmp_ok_reg;
	logic        cmp_done_reg;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst || sel_rise) begin
			cdly_reg     <= 32'h0;
			cmp_done_reg <= 1'b0;
			cmp_ok_reg   <= 1'b0;
		end else if (op_reg == CSC_OP_NV_RD && idx_reg == 4'(3 + CMP_BYTES)
			&& !cmp_done_reg) begin
			// R14 wait then present compare outcome
			if (cdly_reg == 32'(CMP_DELAY - 1)) begin
				cmp_done_reg <= 1'b1;
				cmp_ok_reg   <= o_ref_on && o_access_on && (cmp_reg == cmp_ref);
			end else
				cdly_reg <= cdly_reg + 32'h1;
		end
	end

	logic        flag_reg;
	logic [23:0] tx_word;
	logic [7:0]  tx_byte_reg;

	// R23 R24 flag drops on new result while run_reg is set, select pulse restores link
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			flag_reg <= 1'b0;
		else if (i_result_valid && run_reg)
			flag_reg <= 1'b1;
		else if (sel_rise)
			flag_reg <= 1'b0;
	end

	always_comb begin
		tx_word = 24'h0;
		case (op_reg)
			CSC_OP_RAM_RD:  tx_word = ram_mem[addr_hi_reg[6:0]];
			CSC_OP_USER_RD: begin
				// R15 user area only, low byte first
				if (nv_addr >= USER_FIRST_WORD)
					tx_word = {nv_mem[nv_addr][7:0], nv_mem[nv_addr][15:8], 8'h00};
			end
			CSC_OP_NV_RD:   tx_word = {24{cmp_ok_reg}};
			default:        tx_word = 24'h0;
		endcase
	end

	// Byte to present, loaded in system domain
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			tx_byte_reg <= 8'h00;
		else if (op_reg == CSC_OP_NV_RD)
			tx_byte_reg <= cmp_done_reg ? {8{cmp_ok_reg}} : 8'h00;
		else if (op_reg == CSC_OP_USER_RD && idx_reg >= 4'h2)
			tx_byte_reg <= idx_reg == 4'h2 ? tx_word[23:16] : tx_word[15:8];
		else if (op_reg == CSC_OP_RAM_RD && idx_reg >= 4'h2) begin
			// R25 three result bytes after opcode and address
			case (idx_reg)
				4'h2:    tx_byte_reg <= tx_word[23:16];
				4'h3:    tx_byte_reg <= tx_word[15:8];
				default: tx_byte_reg <= tx_word[7:0];
			endcase
		end else
			tx_byte_reg <= 8'h00;
	end

	// R1 R27 data launched on rising edge for falling-edge capture, msb first
	always_ff @(posedge i_link_clock or posedge i_chip_select_low) begin
		if (i_chip_select_low)
			lk_out_reg <= 1'b0;
		else
			lk_out_reg <= tx_byte_reg[3'h7 - lk_bit_reg];
	end

	assign o_serial_out      = flag_reg ? 1'b0 : (run_reg && sel_lvl ? 1'b1 : lk_out_reg);
	assign o_serial_out_oe_n = !en_lvl;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence s_select_pulse;
		sel_rise;
	endsequence

	property p_flag_clear;
		@(posedge i_clock) disable iff (i_sys_rst)
		s_select_pulse && !i_result_valid |=> !flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag kept after select pulse"); // R24

	property p_flag_low;
		@(posedge i_clock) disable iff (i_sys_rst)
		flag_reg |-> !o_serial_out;
	endproperty
	a_flag_low: assert property (p_flag_low) else $error("flag not driving line low"); // R23

	property p_start_single;
		@(posedge i_clock) disable iff (i_sys_rst)
		cmd_stb && din == CMD_START_SINGLE |=> o_start_single ##1 run_reg;
	endproperty
	a_start_single: assert property (p_start_single) else $error("single start missed"); // R10

	property p_power;
		@(posedge i_clock) disable iff (i_sys_rst)
		cmd_stb && din == CMD_POWER_RESET |=> o_power_reset ##1 !o_ref_on && !o_access_on;
	endproperty
	a_power: assert property (p_power) else $error("power reset missed"); // R9

	property p_result_addr;
		@(posedge i_clock) disable iff (i_sys_rst)
		i_result_valid && !byte_stb |-> ram_wr && ram_wa == (i_program_stored ? 7'h14 : 7'h00);
	endproperty
	a_result_addr: assert property (p_result_addr) else $error("result address wrong"); // R26

	property p_cmp_delay;
		@(posedge i_clock) disable iff (i_sys_rst)
		$rose(cmp_done_reg) |-> cdly_reg == 32'(CMP_DELAY - 1);
	endproperty
	a_cmp_delay: assert property (p_cmp_delay) else $error("compare delay wrong"); // R14

	property p_ram_write;
		@(posedge i_clock) disable iff (i_sys_rst)
		ram_wr && byte_stb |-> op_reg == CSC_OP_RAM_WR && idx_reg == 4'h4;
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("ram write framing wrong"); // R8

	property p_ref_on;
		@(posedge i_clock) disable iff (i_sys_rst)
		cmd_stb && din == CMD_REF_ON |=> ##1 o_ref_on;
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference not enabled"); // R11
endmodule : csc_slave

// file: rtl/csc_sync.sv
`timescale 1ns/1ps
module csc_sync (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_async,
	output logic      o_level,
	output logic      o_rise
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;

	// -----------------------------------------------------------------
	// Three stages; change taken when stages two and three agree
	// -----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				lvl_reg <= s3_reg;
		end
	end

	assign o_level = lvl_reg;
	assign o_rise  = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
endmodule : csc_sync

// file: test/csc_spi_master.sv
`timescale 1ns/1ps
module csc_spi_master (
	input  wire logic i_serial_out,
	output logic      o_link_clock,
	output logic      o_chip_select_low,
	output logic      o_serial_in_line
);
	// half period of the bench link clock
	localparam int HALF = 32;
	logic [7:0] rx_q[$];

	initial begin
		o_link_clock      = 1'b0;
		o_chip_select_low = 1'b1;
		o_serial_in_line  = 1'b0;
	end

	// Clock stands low between bytes and frames
	task automatic frame(input logic [7:0] tx[$], input bit pulse);
		logic [7:0] rx;
		rx_q.delete();
		if (pulse) begin
			o_chip_select_low = 1'b1;
			#(16*HALF);
			o_chip_select_low = 1'b0;
			#(16*HALF);
		end
		foreach (tx[i]) begin
			for (int b = 7; b >= 0; b--) begin
				o_link_clock     = 1'b1;
				o_serial_in_line = tx[i][b];
				#HALF;
				rx[b]        = i_serial_out;
				o_link_clock = 1'b0;
				#HALF;
			end
			rx_q.push_back(rx);
			#(4*HALF);
		end
		// Released line shows inverse
		o_serial_in_line = ~o_serial_in_line;
	endtask : frame
endmodule : csc_spi_master

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench
	import csc_pkg::*;
;
	localparam int CMP = 20;
	logic        i_clock;
	logic        i_sys_rst;
	logic        i_serial_port_select;
	logic        i_program_stored;
	logic        i_result_valid;
	logic [23:0] i_bridge_result;
	wire logic   link_clock;
	wire logic   select_low;
	wire logic   serial_in;
	wire logic   serial_out;
	wire logic   oe_n;
	wire logic   [4:0] strobes;
	wire logic   ref_on;
	wire logic   access_on;
	wire logic   programming;
	int          strobe_cnt[5];
	int          error_cnt = 0;
	int          num_checks = 0;

	csc_slave #(.CMP_DELAY(CMP)) u_csc_slave (
		.i_clock             (i_clock),
		.i_sys_rst           (i_sys_rst),
		.i_link_clock        (link_clock),
		.i_chip_select_low   (select_low),
		.i_serial_in_line    (serial_in),
		.i_serial_port_select(i_serial_port_select),
		.i_program_stored    (i_program_stored),
		.i_result_valid      (i_result_valid),
		.i_bridge_result     (i_bridge_result),
		.o_serial_out        (serial_out),
		.o_serial_out_oe_n   (oe_n),
		.o_power_reset       (strobes[0]),
		.o_init_reset        (strobes[1]),
		.o_display_refresh   (strobes[2]),
		.o_start_continuous  (strobes[3]),
		.o_start_single      (strobes[4]),
		.o_ref_on            (ref_on),
		.o_access_on         (access_on),
		.o_programming       (programming)
	);

	csc_spi_master master (
		.i_serial_out     (serial_out),
		.o_link_clock     (link_clock),
		.o_chip_select_low(select_low),
		.o_serial_in_line (serial_in)
	);

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		for (int j = 0; j < 5; j++) begin
			if (strobes[j] === 1'b1) begin
				strobe_cnt[j]++;
			end
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic clk(input int n);
		repeat (n) @(negedge i_clock);
	endtask : clk

	task automatic cmd(input logic [7:0] c);
		master.frame('{c}, 1'b1);
		clk(20);
	endtask : cmd

	task automatic read_word(input logic [7:0] a, input logic [23:0] exp);
		master.frame('{CMD_RAM_READ, a, 8'h00, 8'h00, 8'h00}, 1'b1);
		check("ram word", exp, {master.rx_q[2], master.rx_q[3], master.rx_q[4]});
	endtask : read_word

	task automatic pulse_result(input logic [23:0] v);
		@(negedge i_clock);
		i_bridge_result = v;
		i_result_valid  = 1'b1;
		@(negedge i_clock);
		i_result_valid  = 1'b0;
		clk(20);
	endtask : pulse_result

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_ref_access();
		cmd(CMD_REF_ON);
		cmd(CMD_ACCESS_ON);
		check("ref_on", 1, ref_on);
		check("access_on", 1, access_on);
		cmd(CMD_REF_OFF);
		cmd(CMD_ACCESS_OFF);
		check("ref_on", 0, ref_on);
		check("access_on", 0, access_on);
		cmd(CMD_REF_ON);
		cmd(CMD_ACCESS_ON);
		$display("test ref_access done");
	endtask : test_ref_access

	task automatic test_strobes();
		logic [7:0] c[5] = '{CMD_POWER_RESET, CMD_INIT_RESET, CMD_DISPLAY_NEW,
			CMD_START_CONT, CMD_START_SINGLE};
		int snap[5];
		for (int k = 0; k < 5; k++) begin
			snap = strobe_cnt;
			cmd(c[k]);
			for (int j = 0; j < 5; j++) begin
				check("strobe count", j == k, strobe_cnt[j] - snap[j]);
			end
			// rest after reset commands, no auto config
			if (k < 2) #200us;
		end
		check("ref_on after reset", 0, ref_on);
		check("access_on after reset", 0, access_on);
		check("oe_n", 0, oe_n);
		$display("test strobes done");
	endtask : test_strobes

	task automatic test_ram();
		logic [7:0]  a;
		logic [23:0] d;
		for (int i = 0; i < 2; i++) begin
			a = i ? 8'h42 : 8'h30;
			d = 24'hA5C33C ^ {3{a}};
			master.frame('{CMD_RAM_WRITE, a, d[23:16], d[15:8], d[7:0]}, 1'b1);
			#10us;
			read_word(a, d);
		end
		$display("test ram done");
	endtask : test_ram

	task automatic test_result();
		i_program_stored = 1'b0;
		pulse_result(24'h3C5A96);
		check("result flag", 0, serial_out);
		read_word(RESULT_RAM_ADDR, 24'h3C5A96);
		i_program_stored = 1'b1;
		pulse_result(24'h0F1E2D);
		check("result flag", 0, serial_out);
		read_word(RESULT_SRC_ADDR, 24'h0F1E2D);
		read_word(RESULT_RAM_ADDR, 24'h3C5A96);
		$display("test result done");
	endtask : test_result

	task automatic test_nv();
		logic [7:0] w[$];
		w = '{CMD_NV_WRITE, 8'h01, 8'h10};
		for (int i = 0; i < 6; i++) begin
			w.push_back(8'h34 + 8'(i));
			w.push_back(8'h12);
		end
		master.frame(w, 1'b1);
		clk(20);
		check("refused programming", 0, programming);
		cmd(CMD_REF_ON);
		cmd(CMD_ACCESS_ON);
		master.frame(w[0:12], 1'b1);
		clk(20);
		check("programming early", 0, programming);
		master.frame(w[13:14], 1'b0);
		clk(20);
		check("programming", 1, programming);
		master.frame('{8'h00}, 1'b0);
		clk(20);
		check("programming end", 0, programming);
		w = '{CMD_NV_BERASE, 8'h02, 8'h55};
		repeat (12) w.push_back(8'hC3);
		master.frame(w, 1'b1);
		clk(20);
		check("erase programming", 1, programming);
		master.frame('{8'h00}, 1'b0);
		for (int m = 0; m < 2; m++) begin
			w = '{CMD_NV_READ, 8'h02, 8'h06};
			repeat (8) w.push_back(m ? 8'h5A : 8'h00);
			master.frame(w, 1'b1);
			clk(CMP + 20);
			master.frame('{8'h00}, 1'b0);
			check("compare result", m ? 8'h00 : 8'hFF, master.rx_q[0]);
		end
		$display("test nv done");
	endtask : test_nv

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	initial begin
		i_sys_rst            = 1'b1;
		i_serial_port_select = 1'b1;
		i_program_stored     = 1'b0;
		i_result_valid       = 1'b0;
		i_bridge_result      = 24'h000000;
		clk(20);
		i_sys_rst = 1'b0;
		clk(10);
		test_ref_access();
		test_strobes();
		test_ram();
		test_result();
		test_nv();
		summarize();
	end

	initial begin
		#600us;
		error_cnt++;
		summarize();
	end
endmodule : testbench
